//--- udmac_channel.sv
// one usb device dma channel: apb registers, descriptor fetch, byte-aligned word mover
// assumes a same-clock system bus port and a byte-wide endpoint bank port
//
// Operation
// RULE1: next pointer holds descriptor address bits 31:4
// RULE2: bus address output is word aligned
// RULE3: buffers start and end on any byte
// RULE4: software writes address only while disabled
// RULE5: address advances by access bytes at completion
// RULE6: accesses carry four bytes except edges
// RULE7: start from write or descriptor, end configurable
// RULE8: zero byte length means 64kB transfer
// RULE9: unknown size: software programs zero length
// RULE10: length changes ignored while channel enabled
// RULE11: burst lock control drives bus lock
// RULE12: descriptor loaded interrupt when enabled
// RULE13: end of buffer interrupt at count zero
// RULE14: end of transfer irq needs close enable
// RULE15: end of buffer completes usb transfer
// RULE16: short out packet closes transfer
// RULE17: load next descriptor after transfer end
// RULE18: two control bits select four commands
// RULE19: disabled plus load skips to next descriptor
// RULE20: enable write sets enabled status
// RULE21: disable drains fifo before clearing status
// RULE22: end of buffer clears enable control
// RULE23: remaining count decrements per access
// RULE24: status flags clear on status read
// RULE25: enabled status timing and clearing
// RULE26: interrupt is or of enabled flags
`include "udmac_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module udmac_channel (
	input wire logic ref_clk_i,
	input wire logic sys_rst_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [11:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	output logic mem_req_o,
	output logic mem_we_o,
	output logic [31:0] mem_addr_o,
	output logic [3:0] mem_be_o,
	output logic [31:0] mem_wdata_o,
	output logic mem_lock_o,
	input wire logic mem_ack_i,
	input wire logic [31:0] mem_rdata_i,
	input wire logic ep_dir_in_i,
	input wire logic ep_req_i,
	input wire logic ep_short_end_i,
	input wire logic ep_rx_valid_i,
	input wire logic [7:0] ep_rx_data_i,
	output logic ep_rx_ready_o,
	output logic ep_tx_valid_o,
	output logic [7:0] ep_tx_data_o,
	input wire logic ep_tx_ready_i,
	output logic ep_end_o,
	output logic irq_o
);

////////////////////////////////////////////////////////////////////////////////
udmac_pkg::udmac_state_e state_q, state_d;
udmac_pkg::udmac_ctl_s ctl_q, ctl_d;
logic [27:0] next_q, next_d;
logic [31:0] addr_q, addr_d;
logic [16:0] cnt_q, cnt_d;
logic stat_en_q, stat_en_d;
logic f_dl_q, f_dl_d, f_eob_q, f_eob_d, f_eot_q, f_eot_d;
logic [31:0] buf_q, buf_d;
logic [2:0] fill_q, fill_d, acc_q, acc_d;
logic [1:0] lane_q, lane_d, idx_q, idx_d;
logic close_q, close_d;
logic req_q, req_d, we_q, we_d, lock_q, lock_d;
logic [31:0] maddr_q, maddr_d, wdata_q, wdata_d, prdata_q, prdata_d;
logic [3:0] be_q, be_d;
logic rxr_q, rxr_d, txv_q, txv_d, end_q, end_d, irq_q, irq_d;
logic [7:0] txd_q, txd_d;
logic pready_q, pready_d, pslverr_q, pslverr_d;
logic setup, acc_wr, acc_rd, hit, active, desc_go, end_buf, end_eot;
logic [2:0] avail, n;
logic [1:0] bi;
logic [31:0] stat_word;

function automatic logic [3:0] lane_mask(input logic [1:0] lane, input logic [2:0] cnt);
	logic [3:0] m;
	m = 4'h0;
	for (int i = 0; i < 4; i++) begin
		m[i] = (3'(i) >= {1'b0, lane}) && (3'(i) < ({1'b0, lane} + cnt));
	end
	return m;
endfunction

function automatic logic [16:0] len_to_cnt(input logic [15:0] len);
	return (len == 16'h0000) ? `UDMAC_FULL_LEN : {1'b0, len}; // [RULE8]
endfunction

////////////////////////////////////////////////////////////////////////////////
always_comb begin
	state_d = state_q;
	ctl_d = ctl_q;
	next_d = next_q;
	addr_d = addr_q;
	cnt_d = cnt_q;
	stat_en_d = stat_en_q;
	buf_d = buf_q;
	fill_d = fill_q;
	acc_d = acc_q;
	lane_d = lane_q;
	idx_d = idx_q;
	close_d = close_q;
	req_d = req_q;
	we_d = we_q;
	maddr_d = maddr_q;
	wdata_d = wdata_q;
	be_d = be_q;
	txv_d = txv_q;
	txd_d = txd_q;
	end_d = 1'b0;
	desc_go = 1'b0;
	end_buf = 1'b0;
	end_eot = 1'b0;
	setup = psel_i && !penable_i;
	acc_wr = psel_i && penable_i && pready_q && pwrite_i;
	acc_rd = psel_i && penable_i && pready_q && !pwrite_i;
	hit = (paddr_i == `UDMAC_OFS_NEXT) || (paddr_i == `UDMAC_OFS_ADDR) ||
		(paddr_i == `UDMAC_OFS_CTRL) || (paddr_i == `UDMAC_OFS_STAT);
	active = (state_q == udmac_pkg::ST_FILL) || (state_q == udmac_pkg::ST_MEM) ||
		(state_q == udmac_pkg::ST_SEND);
	avail = `UDMAC_WORD_BYTES - {1'b0, addr_q[1:0]};
	n = (cnt_q < {14'h0000, avail}) ? cnt_q[2:0] : avail; // [RULE6]
	bi = 2'(addr_q[1:0] + fill_q[1:0]);
	// status flags: a read clears, a same-cycle event below still sets
	f_dl_d = f_dl_q && !(acc_rd && paddr_i == `UDMAC_OFS_STAT); // [RULE24]
	f_eob_d = f_eob_q && !(acc_rd && paddr_i == `UDMAC_OFS_STAT); // [RULE24]
	f_eot_d = f_eot_q && !(acc_rd && paddr_i == `UDMAC_OFS_STAT); // [RULE24]
	stat_word = `UDMAC_RESET_WORD;
	stat_word[`UDMAC_ST_CNT_LSB +: 16] = cnt_q[15:0];
	stat_word[`UDMAC_ST_DL] = f_dl_q;
	stat_word[`UDMAC_ST_EOB] = f_eob_q;
	stat_word[`UDMAC_ST_EOT] = f_eot_q;
	stat_word[`UDMAC_ST_ACT] = active;
	stat_word[`UDMAC_ST_EN] = stat_en_q;

	case (state_q)
		udmac_pkg::ST_IDLE: begin
			if (stat_en_q && !ctl_q.en) begin
				stat_en_d = 1'b0; // [RULE18] [RULE21]
			end else if (stat_en_q && ctl_q.en && ep_req_i && cnt_q != 17'h00000) begin
				// [RULE20] pending request starts or resumes the transfer
				if (ep_dir_in_i) begin
					state_d = udmac_pkg::ST_MEM;
					req_d = 1'b1;
					we_d = 1'b0;
					maddr_d = {addr_q[31:2], 2'b00}; // [RULE2]
					be_d = lane_mask(addr_q[1:0], n);
					acc_d = n;
					lane_d = addr_q[1:0];
				end else begin
					state_d = udmac_pkg::ST_FILL;
					fill_d = 3'h0;
					close_d = 1'b0;
				end
			end else if (!stat_en_q && ctl_q.ldnxt && ep_req_i) begin
				desc_go = 1'b1; // [RULE19] [RULE18]
			end
		end
		udmac_pkg::ST_DESC: begin
			if (mem_ack_i) begin
				case (idx_q)
					2'h0: next_d = mem_rdata_i[31:4]; // [RULE1]
					2'h1: addr_d = mem_rdata_i; // [RULE7]
					default: begin
						ctl_d.en = mem_rdata_i[`UDMAC_CTL_EN];
						ctl_d.ldnxt = mem_rdata_i[`UDMAC_CTL_LDNXT];
						ctl_d.bclose = mem_rdata_i[`UDMAC_CTL_BCLOSE];
						ctl_d.dmaend = mem_rdata_i[`UDMAC_CTL_DMAEND];
						ctl_d.eotie = mem_rdata_i[`UDMAC_CTL_EOTIE];
						ctl_d.eobie = mem_rdata_i[`UDMAC_CTL_EOBIE];
						ctl_d.dlie = mem_rdata_i[`UDMAC_CTL_DLIE];
						ctl_d.lock = mem_rdata_i[`UDMAC_CTL_LOCK];
						if (!stat_en_q) begin
							ctl_d.len = mem_rdata_i[`UDMAC_LEN_LSB +: 16]; // [RULE10]
							cnt_d = len_to_cnt(mem_rdata_i[`UDMAC_LEN_LSB +: 16]);
						end
					end
				endcase
				if (idx_q == `UDMAC_DESC_LAST) begin
					req_d = 1'b0;
					f_dl_d = 1'b1; // [RULE12] [RULE24]
					stat_en_d = 1'b1; // [RULE25]
					state_d = udmac_pkg::ST_IDLE;
				end else begin
					idx_d = 2'(idx_q + 2'h1);
					maddr_d = {next_q, `UDMAC_DESC_ALIGN} + {28'h0000000, idx_d, 2'b00};
				end
			end
		end
		udmac_pkg::ST_FILL: begin
			// out direction: bytes gather into the word buffer at their lanes
			if (ep_rx_valid_i && rxr_q) begin
				buf_d[{bi, 3'b000} +: 8] = ep_rx_data_i; // [RULE3]
				fill_d = 3'(fill_q + 3'h1);
				if (fill_d == n) begin
					state_d = udmac_pkg::ST_MEM;
				end
			end else if (ep_short_end_i && ctl_q.bclose) begin
				close_d = 1'b1; // [RULE16]
				if (fill_q != 3'h0) begin
					state_d = udmac_pkg::ST_MEM;
				end else begin
					end_eot = 1'b1;
				end
			end else if (!ctl_q.en) begin
				// partial word still goes out before the status drops
				if (fill_q != 3'h0) begin
					state_d = udmac_pkg::ST_MEM; // [RULE21]
				end else begin
					stat_en_d = 1'b0;
					state_d = udmac_pkg::ST_IDLE;
				end
			end
			if (state_d == udmac_pkg::ST_MEM) begin
				req_d = 1'b1;
				we_d = 1'b1;
				maddr_d = {addr_q[31:2], 2'b00}; // [RULE2]
				be_d = lane_mask(addr_q[1:0], fill_d);
				wdata_d = buf_d;
				acc_d = fill_d;
			end
		end
		udmac_pkg::ST_MEM: begin
			if (mem_ack_i) begin
				req_d = 1'b0;
				addr_d = addr_q + {29'h00000000, acc_q}; // [RULE5]
				cnt_d = cnt_q - {14'h0000, acc_q}; // [RULE23]
				if (!we_q) begin
					buf_d = mem_rdata_i;
					fill_d = 3'h0;
					txv_d = 1'b1;
					txd_d = mem_rdata_i[{lane_q, 3'b000} +: 8];
					state_d = udmac_pkg::ST_SEND;
				end else if (cnt_d == 17'h00000) begin
					end_buf = 1'b1;
				end else if (close_q) begin
					end_eot = 1'b1;
				end else begin
					if (!ctl_q.en) begin
						stat_en_d = 1'b0; // [RULE21]
					end
					state_d = udmac_pkg::ST_IDLE;
				end
			end
		end
		udmac_pkg::ST_SEND: begin
			if (txv_q && ep_tx_ready_i) begin
				fill_d = 3'(fill_q + 3'h1);
				txd_d = buf_q[{2'(lane_q + fill_d[1:0]), 3'b000} +: 8];
				if (fill_d == acc_q) begin
					txv_d = 1'b0;
					if (cnt_q == 17'h00000) begin
						end_buf = 1'b1;
					end else begin
						state_d = udmac_pkg::ST_IDLE;
					end
				end
			end
		end
		default: begin
			state_d = udmac_pkg::ST_IDLE;
		end
	endcase

	if (end_buf) begin
		f_eob_d = 1'b1; // [RULE13] [RULE24]
		stat_en_d = 1'b0; // [RULE25]
		ctl_d.en = 1'b0; // [RULE22]
		end_d = ctl_q.dmaend; // [RULE15]
	end
	if (end_eot) begin
		f_eot_d = 1'b1; // [RULE14] [RULE24]
		stat_en_d = 1'b0; // [RULE25]
	end
	if (end_buf || end_eot) begin
		state_d = udmac_pkg::ST_IDLE;
		desc_go = ctl_q.ldnxt; // [RULE17] [RULE18]
	end
	if (desc_go) begin
		state_d = udmac_pkg::ST_DESC;
		idx_d = 2'h0;
		req_d = 1'b1;
		we_d = 1'b0;
		be_d = lane_mask(2'h0, `UDMAC_WORD_BYTES);
		maddr_d = {next_q, `UDMAC_DESC_ALIGN}; // [RULE1]
	end

	// software writes come last so they win over the engine
	pready_d = setup;
	pslverr_d = setup && !hit;
	prdata_d = prdata_q;
	if (setup) begin
		case (paddr_i)
			`UDMAC_OFS_NEXT: prdata_d = {next_q, 4'h0};
			`UDMAC_OFS_ADDR: prdata_d = addr_q;
			`UDMAC_OFS_CTRL: prdata_d = {ctl_q.len, 8'h00, ctl_q.lock, ctl_q.dlie, ctl_q.eobie,
				ctl_q.eotie, ctl_q.dmaend, ctl_q.bclose, ctl_q.ldnxt, ctl_q.en};
			`UDMAC_OFS_STAT: prdata_d = stat_word;
			default: prdata_d = `UDMAC_RESET_WORD;
		endcase
	end
	if (acc_wr) begin
		case (paddr_i)
			`UDMAC_OFS_NEXT: next_d = pwdata_i[31:4]; // [RULE1]
			`UDMAC_OFS_ADDR: begin
				if (!stat_en_q) begin
					addr_d = pwdata_i; // [RULE4] [RULE7]
				end
			end
			`UDMAC_OFS_CTRL: begin
				ctl_d.en = pwdata_i[`UDMAC_CTL_EN];
				ctl_d.ldnxt = pwdata_i[`UDMAC_CTL_LDNXT];
				ctl_d.bclose = pwdata_i[`UDMAC_CTL_BCLOSE];
				ctl_d.dmaend = pwdata_i[`UDMAC_CTL_DMAEND];
				ctl_d.eotie = pwdata_i[`UDMAC_CTL_EOTIE];
				ctl_d.eobie = pwdata_i[`UDMAC_CTL_EOBIE];
				ctl_d.dlie = pwdata_i[`UDMAC_CTL_DLIE];
				ctl_d.lock = pwdata_i[`UDMAC_CTL_LOCK];
				if (!stat_en_q) begin
					ctl_d.len = pwdata_i[`UDMAC_LEN_LSB +: 16]; // [RULE10]
					cnt_d = len_to_cnt(pwdata_i[`UDMAC_LEN_LSB +: 16]);
				end
				if (pwdata_i[`UDMAC_CTL_EN]) begin
					stat_en_d = 1'b1; // [RULE20] [RULE25]
				end
			end
			default: begin
			end
		endcase
	end

	rxr_d = (state_d == udmac_pkg::ST_FILL) && !ep_dir_in_i && (fill_d != n);
	// lock only spans data moves, never descriptor fetches
	lock_d = ctl_d.lock && ((state_d == udmac_pkg::ST_FILL) ||
		(state_d == udmac_pkg::ST_MEM) || (state_d == udmac_pkg::ST_SEND)); // [RULE11]
	irq_d = (f_dl_d && ctl_d.dlie) || (f_eob_d && ctl_d.eobie) ||
		(f_eot_d && ctl_d.eotie && ctl_d.bclose); // [RULE26] [RULE12] [RULE13] [RULE14]
end

////////////////////////////////////////////////////////////////////////////////
always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
	if (sys_rst_i) begin
		state_q <= udmac_pkg::ST_IDLE;
		ctl_q <= '0;
		next_q <= 28'h0000000;
		addr_q <= `UDMAC_RESET_WORD;
		cnt_q <= `UDMAC_FULL_LEN;
		stat_en_q <= 1'b0;
		f_dl_q <= 1'b0;
		f_eob_q <= 1'b0;
		f_eot_q <= 1'b0;
		buf_q <= `UDMAC_RESET_WORD;
		fill_q <= 3'h0;
		acc_q <= 3'h0;
		lane_q <= 2'h0;
		idx_q <= 2'h0;
		close_q <= 1'b0;
		req_q <= 1'b0;
		we_q <= 1'b0;
		lock_q <= 1'b0;
		maddr_q <= `UDMAC_RESET_WORD;
		wdata_q <= `UDMAC_RESET_WORD;
		prdata_q <= `UDMAC_RESET_WORD;
		be_q <= 4'h0;
		rxr_q <= 1'b0;
		txv_q <= 1'b0;
		txd_q <= 8'h00;
		end_q <= 1'b0;
		irq_q <= 1'b0;
		pready_q <= 1'b0;
		pslverr_q <= 1'b0;
	end else begin
		state_q <= state_d;
		ctl_q <= ctl_d;
		next_q <= next_d;
		addr_q <= addr_d;
		cnt_q <= cnt_d;
		stat_en_q <= stat_en_d;
		f_dl_q <= f_dl_d;
		f_eob_q <= f_eob_d;
		f_eot_q <= f_eot_d;
		buf_q <= buf_d;
		fill_q <= fill_d;
		acc_q <= acc_d;
		lane_q <= lane_d;
		idx_q <= idx_d;
		close_q <= close_d;
		req_q <= req_d;
		we_q <= we_d;
		lock_q <= lock_d;
		maddr_q <= maddr_d;
		wdata_q <= wdata_d;
		prdata_q <= prdata_d;
		be_q <= be_d;
		rxr_q <= rxr_d;
		txv_q <= txv_d;
		txd_q <= txd_d;
		end_q <= end_d;
		irq_q <= irq_d;
		pready_q <= pready_d;
		pslverr_q <= pslverr_d;
	end
end

assign prdata_o = prdata_q;
assign pready_o = pready_q;
assign pslverr_o = pslverr_q;
assign mem_req_o = req_q;
assign mem_we_o = we_q;
assign mem_addr_o = maddr_q;
assign mem_be_o = be_q;
assign mem_wdata_o = wdata_q;
assign mem_lock_o = lock_q;
assign ep_rx_ready_o = rxr_q;
assign ep_tx_valid_o = txv_q;
assign ep_tx_data_o = txd_q;
assign ep_end_o = end_q;
assign irq_o = irq_q;

endmodule // udmac_channel
`default_nettype wire

//--- udmac_cfg.svh
// register offsets, field positions, reset values and fixed counts of the dma channel
// assumes inclusion by the channel module and by the port checker
`ifndef UDMAC_CFG_SVH
`define UDMAC_CFG_SVH
`define UDMAC_OFS_NEXT 12'h310
`define UDMAC_OFS_ADDR 12'h314
`define UDMAC_OFS_CTRL 12'h318
`define UDMAC_OFS_STAT 12'h31C
`define UDMAC_CTL_EN 0
`define UDMAC_CTL_LDNXT 1
`define UDMAC_CTL_BCLOSE 2
`define UDMAC_CTL_DMAEND 3
`define UDMAC_CTL_EOTIE 4
`define UDMAC_CTL_EOBIE 5
`define UDMAC_CTL_DLIE 6
`define UDMAC_CTL_LOCK 7
`define UDMAC_LEN_LSB 16
`define UDMAC_ST_EN 0
`define UDMAC_ST_ACT 1
`define UDMAC_ST_EOT 4
`define UDMAC_ST_EOB 5
`define UDMAC_ST_DL 6
`define UDMAC_ST_CNT_LSB 16
`define UDMAC_FULL_LEN 17'h10000
`define UDMAC_WORD_BYTES 3'h4
`define UDMAC_DESC_LAST 2'h2
`define UDMAC_DESC_ALIGN 4'h0
`define UDMAC_RESET_WORD 32'h00000000
`endif

//--- udmac_pkg.sv
// types shared by the usb device dma channel
// assumes udmac_cfg.svh on the include path
package udmac_pkg;
	typedef enum logic [4:0] {
		ST_IDLE = 5'h01,
		ST_DESC = 5'h02,
		ST_FILL = 5'h04,
		ST_MEM = 5'h08,
		ST_SEND = 5'h10
	} udmac_state_e;
	typedef struct packed {
		logic [15:0] len;
		logic lock;
		logic dlie;
		logic eobie;
		logic eotie;
		logic dmaend;
		logic bclose;
		logic ldnxt;
		logic en;
	} udmac_ctl_s;
endpackage

//--- udmac_props.sv
// port checker for the usb device dma channel
// assumes one clock domain and binding onto udmac_channel
`include "udmac_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module udmac_props (
	input wire logic ref_clk_i,
	input wire logic sys_rst_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [11:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	input wire logic pready_o,
	input wire logic pslverr_o,
	input wire logic mem_req_o,
	input wire logic [31:0] mem_addr_o,
	input wire logic [3:0] mem_be_o,
	input wire logic mem_lock_o,
	input wire logic mem_ack_i,
	input wire logic ep_tx_valid_o,
	input wire logic [7:0] ep_tx_data_o,
	input wire logic ep_tx_ready_i,
	input wire logic ep_end_o
);
	default clocking cb @(posedge ref_clk_i);
	endclocking
	default disable iff (sys_rst_i);
	////////////////////////////////////////
	// lock control as last written; descriptor loads are not tracked
	logic lock_q, lock_d;
	always_comb begin
		lock_d = lock_q;
		if (psel_i && penable_i && pready_o && pwrite_i && paddr_i == `UDMAC_OFS_CTRL)
			lock_d = pwdata_i[`UDMAC_CTL_LOCK];
	end
	always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i)
			lock_q <= 1'b0;
		else
			lock_q <= lock_d;
	end
	////////////////////////////////////////
	chk_addr_word: assert property (mem_req_o |-> mem_addr_o[1:0] == 2'b00)
		else $error("bus address not word aligned");
	chk_be_lanes: assert property (mem_req_o |->
		mem_be_o inside {4'h1, 4'h2, 4'h3, 4'h4, 4'h6, 4'h7, 4'h8, 4'hC, 4'hE, 4'hF})
		else $error("byte lanes not contiguous");
	chk_req_hold: assert property (mem_req_o && !mem_ack_i |=>
		mem_req_o && $stable(mem_addr_o) && $stable(mem_be_o))
		else $error("bus request changed before ack");
	chk_ack_drop: assert property (mem_req_o && mem_ack_i |=> !mem_req_o)
		else $error("bus request held after ack");
	chk_lock_off: assert property (!lock_q && !$past(lock_q) |-> !mem_lock_o)
		else $error("bus locked with lock control clear");
	chk_apb_answer: assert property (psel_i && !penable_i |=> pready_o ##1 !pready_o)
		else $error("apb answer not one cycle after setup");
	chk_unmapped_err: assert property (psel_i && !penable_i &&
		!(paddr_i inside {`UDMAC_OFS_NEXT, `UDMAC_OFS_ADDR, `UDMAC_OFS_CTRL, `UDMAC_OFS_STAT})
		|=> pslverr_o && pready_o)
		else $error("unmapped access not flagged");
	chk_tx_hold: assert property (ep_tx_valid_o && !ep_tx_ready_i |=>
		ep_tx_valid_o && $stable(ep_tx_data_o))
		else $error("in byte dropped before taken");
	chk_end_pulse: assert property (ep_end_o |=> !ep_end_o)
		else $error("end output longer than one cycle");
	cover property (mem_req_o && mem_ack_i);
	cover property (ep_end_o);
	cover property (pslverr_o);
	cover property (mem_lock_o);
endmodule // udmac_props
bind udmac_channel udmac_props udmac_props_i (.ref_clk_i, .sys_rst_i, .psel_i, .penable_i,
	.pwrite_i, .paddr_i, .pwdata_i, .pready_o, .pslverr_o, .mem_req_o, .mem_addr_o,
	.mem_be_o, .mem_lock_o, .mem_ack_i, .ep_tx_valid_o, .ep_tx_data_o, .ep_tx_ready_i,
	.ep_end_o);
`default_nettype wire

//--- udmac_mem_model.sv
// system bus memory model: reads return an address pattern after a random wait
// assumes one access at a time, same clock as the channel
`timescale 1ns/1ps
`default_nettype none
module udmac_mem_model (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic mem_req_i,
	input wire logic [31:0] mem_addr_i,
	output logic mem_ack_o,
	output logic [31:0] mem_rdata_o
);
	integer seed_m = 7;
	logic [1:0] wait_q;
	// ack closes the access; the channel advances its address there
	always @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			mem_ack_o <= 1'b0;
			wait_q <= 2'h0;
		end else if (mem_ack_o) begin
			mem_ack_o <= 1'b0;
			wait_q <= 2'($random(seed_m));
		end else if (mem_req_i && wait_q == 2'h0)
			mem_ack_o <= 1'b1;
		else if (mem_req_i)
			wait_q <= wait_q - 2'h1;
	end
	// outside the ack the data is inverted so a stale sample cannot match
	assign mem_rdata_o = mem_ack_o ? mem_addr_i ^ 32'h5A3C96F0 : ~(mem_addr_i ^ 32'h5A3C96F0);
endmodule // udmac_mem_model
`default_nettype wire

//--- tb.sv
// self-checking bench: registers over apb, in buffers to a stalling endpoint
// assumes udmac_mem_model on the system bus; short end input held low
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic ref_clk_i = 0, sys_rst_i = 1;
	logic psel = 0, pen = 0, pwr = 0, ep_req = 0, txr = 0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h00000000;
	logic [31:0] prdata, maddr, rdata;
	logic pready, pslverr, req, lock, ack, txv, ep_end, irq, rxr, wen;
	logic rxv = 0, dir_in = 1;
	logic [7:0] rxd = 8'h00;
	logic [3:0] mbe;
	logic [31:0] mwd;
	logic [35:0] w_q[$];
	logic [35:0] e_w;
	logic [7:0] txd;
	logic [64:0] rd_q[$];
	logic [64:0] e_r;
	logic [7:0] tx_q[$];
	integer seed = 28415, fails = 0, cmp_count = 0, ends = 0;
	always #2.5 ref_clk_i = ~ref_clk_i;
	udmac_channel udmac_channel_i (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i),
		.psel_i(psel), .penable_i(pen), .pwrite_i(pwr), .paddr_i(paddr), .pwdata_i(pwdata),
		.prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .mem_req_o(req),
		.mem_we_o(wen), .mem_addr_o(maddr), .mem_be_o(mbe), .mem_wdata_o(mwd),
		.mem_lock_o(lock), .mem_ack_i(ack), .mem_rdata_i(rdata), .ep_dir_in_i(dir_in),
		.ep_req_i(ep_req), .ep_short_end_i(1'b0), .ep_rx_valid_i(rxv), .ep_rx_data_i(rxd),
		.ep_rx_ready_o(rxr),
		.ep_tx_valid_o(txv), .ep_tx_data_o(txd), .ep_tx_ready_i(txr), .ep_end_o(ep_end),
		.irq_o(irq));
	udmac_mem_model udmac_mem_model_i (.clk_i(ref_clk_i), .rst_i(sys_rst_i),
		.mem_req_i(req), .mem_addr_i(maddr), .mem_ack_o(ack), .mem_rdata_o(rdata));
	////////////////////////////////////////
	function automatic logic [7:0] byte_at(input logic [31:0] x);
		logic [31:0] w;
		w = (x & ~32'h3) ^ 32'h5A3C96F0;
		return w[8 * x[1:0] +: 8];
	endfunction
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			fails++;
			$display("mismatch at %0t: got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic finish_test();
		$display("counts: %0d compares, %0d mismatches", cmp_count, fails);
		if (fails == 0 && cmp_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	// called just after a rising edge; d is write data or expected read data
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
		input logic [31:0] m, input logic er);
		integer n;
		rd_q.push_back({er, m, d});
		psel <= 1'b1;
		pwr <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge ref_clk_i);
		pen <= 1'b1;
		n = 0;
		do begin
			@(posedge ref_clk_i);
			n++;
		end while (pready !== 1'b1 && n < 64);
		if (pready !== 1'b1)
			fails++;
		psel <= 1'b0;
		pen <= 1'b0;
		@(posedge ref_clk_i);
	endtask
	////////////////////////////////////////
	always @(posedge ref_clk_i) begin
		txr <= 1'($random(seed));
		rxv <= 1'($random(seed));
		if (rxv && rxr)
			rxd <= rxd + 8'h01;
		if (req && ack && wen) begin
			e_w = w_q.pop_front();
			check(mwd & {{8{e_w[35]}}, {8{e_w[34]}}, {8{e_w[33]}}, {8{e_w[32]}}},
				e_w[31:0]);
			check({28'h0, mbe}, {28'h0, e_w[35:32]});
		end
		if (psel && pen && pready) begin
			e_r = rd_q.pop_front();
			check({31'h0, pslverr}, {31'h0, e_r[64]});
			if (!pwr)
				check(prdata & e_r[63:32], e_r[31:0]);
		end
		if (txv && txr)
			check({24'h0, txd}, {24'h0, tx_q.pop_front()});
		if (ep_end)
			ends++;
	end
	initial begin
		#200000;
		fails++;
		finish_test();
	end
	initial begin
		logic [31:0] a, c, wa, wdt;
		logic [3:0] wbe;
		integer len, k, i, n, rem, j;
		repeat (10) @(posedge ref_clk_i);
		sys_rst_i <= 1'b0;
		@(posedge ref_clk_i);
		apb(0, 12'h314, 32'h0, '1, 0);
		apb(0, 12'h318, 32'h0, '1, 0);
		apb(0, 12'h31C, 32'h0, '1, 0);
		apb(0, 12'h300, 32'h0, '1, 1);
		$display("test reset done");
		for (k = 0; k < 5; k++) begin
			a = 32'h1000 + ($random(seed) & 32'h3F);
			len = 1 + ($random(seed) & 32'hF);
			c = {len[15:0], 8'h00, k[0], 1'b0, ~k[1], 1'b0, 1'b1, 2'b00, 1'b1};
			apb(1, 12'h314, a, 0, 0);
			if (k < 4) begin
				for (i = 0; i < len; i++)
					tx_q.push_back(byte_at(a + i));
			end else begin
				// out buffer: endpoint bytes count up from zero
				dir_in <= 1'b0;
				wa = a;
				rem = len;
				i = 0;
				while (rem > 0) begin
					n = 4 - wa[1:0];
					if (n > rem)
						n = rem;
					wbe = 4'h0;
					wdt = 32'h0;
					for (j = 0; j < n; j++) begin
						wbe[wa[1:0] + j] = 1'b1;
						wdt[8 * (wa[1:0] + j) +: 8] = 8'(i + j);
					end
					w_q.push_back({wbe, wdt});
					wa = wa + n;
					rem = rem - n;
					i = i + n;
				end
			end
			ep_req <= 1'b1;
			apb(1, 12'h318, c, 0, 0);
			n = 0;
			while (ends == k && n < 2000) begin
				@(posedge ref_clk_i);
				n++;
			end
			if (n >= 2000)
				fails++;
			ep_req <= 1'b0;
			@(posedge ref_clk_i);
			check({31'h0, irq}, {31'h0, ~k[1]});
			apb(0, 12'h31C, 32'h20, '1, 0);
			apb(0, 12'h31C, 32'h0, '1, 0);
			check({31'h0, irq}, 32'h0);
			apb(0, 12'h318, c & ~32'h1, '1, 0);
			apb(0, 12'h314, a + len, '1, 0);
			$display("test buffer %0d done", k);
		end
		check(tx_q.size(), 0);
		check(w_q.size(), 0);
		check(ends, 5);
		a = a + len;
		apb(1, 12'h318, 32'h00040001, 0, 0);
		apb(0, 12'h31C, 32'h1, 32'h1, 0);
		apb(1, 12'h314, 32'h2000, 0, 0);
		apb(0, 12'h314, a, '1, 0);
		apb(1, 12'h318, 32'h00080001, 0, 0);
		apb(0, 12'h318, 32'h00040001, '1, 0);
		apb(1, 12'h318, 32'h0, 0, 0);
		apb(0, 12'h31C, 32'h0, 32'h3, 0);
		$display("test refusal done");
		finish_test();
	end
endmodule // tb
`default_nettype wire
